// ### include/vtl_pkg.sv
// constants, types and command map for the output-voltage target logic
package vtl_pkg;
    // command codes reached over the management link
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_MODE         = 8'h20;
    localparam logic [7:0] CMD_COMMAND      = 8'h21;
    localparam logic [7:0] CMD_OFFSET       = 8'h22;
    localparam logic [7:0] CMD_UPPER        = 8'h24;
    localparam logic [7:0] CMD_RATE         = 8'h27;
    localparam logic [7:0] CMD_LOWER        = 8'h2b;
    localparam logic [7:0] CMD_STAT_BYTE    = 8'h78;
    localparam logic [7:0] CMD_STAT_WORD    = 8'h79;
    localparam logic [7:0] CMD_STAT_VOUT    = 8'h7a;
    localparam logic [7:0] CMD_STAT_CML     = 8'h7e;
    localparam logic [7:0] CMD_MISC         = 8'he0;

    // status bit positions
    localparam int STB_NOTA     = 0;
    localparam int STB_CML      = 1;
    localparam int SW_VOUT      = 15;
    localparam int SV_MAXMIN    = 3;
    localparam int CML_INV_CMD  = 7;
    localparam int CML_INV_DATA = 6;

    // misc_config bit positions
    localparam int MISC_RESTORE   = 0;
    localparam int MISC_SRC_PIN   = 1;
    localparam int MISC_MASK_WARN = 2;
    localparam int MISC_MASK_CML  = 3;
    localparam int MISC_SCALE     = 4;
    localparam int MISC_ALERT_RD  = 15;

    // mode byte layout, exponent limits and boot cycle count
    localparam int          MODE_REL      = 7;
    localparam logic [4:0]  EXP_BIAS      = 5'h0c;
    localparam logic signed [4:0] EXP_HI  = -5'sd4;
    localparam logic signed [4:0] EXP_LO  = -5'sd12;
    localparam logic [3:0]  BOOT_CYC      = 4'h4;

    // valid target range per loop scale, in units of 2^-12 V
    localparam logic [15:0] RANGE_S1000 = 16'h0b33;
    localparam logic [15:0] RANGE_S0500 = 16'h1666;
    localparam logic [15:0] RANGE_S0250 = 16'h2ccc;
    localparam logic [15:0] RANGE_S0125 = 16'h6000;

    // saturation limits of the 8-bit offset backup
    localparam logic signed [23:0] BACKUP_MAX = 24'sd127;
    localparam logic signed [23:0] BACKUP_MIN = -24'sd128;

    // reset values
    localparam logic [4:0]  RST_EXP   = 5'h14;
    localparam logic [15:0] RST_UPPER = 16'h6000;
    localparam logic [15:0] RST_LOWER = 16'h0000;
    localparam logic [15:0] RST_RATE  = 16'h0001;
    localparam logic [15:0] RST_MISC  = 16'h0000;

    // link-side handshake states
    typedef enum logic [1:0] {
        LNK_IDLE = 2'b01,
        LNK_BUSY = 2'b10
    } vtl_link_e;

    typedef struct packed {
        logic        wr;
        logic [7:0]  code;
        logic [15:0] data;
    } vtl_req_s;

    typedef struct packed {
        logic        err;
        logic [15:0] data;
    } vtl_rsp_s;

    typedef struct packed {
        logic        warn;
        logic [15:0] code;
    } vtl_tgt_s;
endpackage

// ### hw/vtl_target.sv
// output-voltage target, offset and limit logic with link-side command port
`timescale 1ns/1ps
`default_nettype none

module vtl_target
    import vtl_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        link_clk_i,
    input  wire logic        link_valid_i,
    input  wire vtl_req_s    link_req_i,
    output logic             link_ready_o,
    output logic             link_rsp_valid_o,
    output vtl_rsp_s         link_rsp_o,
    input  wire logic        conv_enable_i,
    input  wire logic        fault_shutdown_i,
    input  wire logic [15:0] voltage_select_pin_i,
    input  wire logic [15:0] nvm_command_i,
    input  wire logic [7:0]  nvm_offset_i,
    input  wire logic        alert_i,
    output logic             alert_o,
    output logic             alert_oe_n_o,
    output logic [15:0]      dac_code_o,
    output logic [7:0]       offset_backup_o
);

    // link-domain state
    typedef struct packed {
        vtl_link_e   st;
        logic        ready;
        logic        req_tgl;
        vtl_req_s    req;
        logic        ack_s1;
        logic        ack_s2;
        logic        rsp_valid;
        vtl_rsp_s    rsp;
    } vtl_lnk_s;

    // core-domain state
    typedef struct packed {
        logic        req_s1;
        logic        req_s2;
        logic        ack_tgl;
        vtl_rsp_s    rsp;
        logic        cen_s1;
        logic        cen_s2;
        logic        flt_s1;
        logic        flt_s2;
        logic        flt_d;
        logic [15:0] pin_s1;
        logic [15:0] pin_s2;
        logic [15:0] nvc_s1;
        logic [15:0] nvc_s2;
        logic [7:0]  nvo_s1;
        logic [7:0]  nvo_s2;
        logic        al_s1;
        logic        al_s2;
        logic [3:0]  boot;
        logic [4:0]  exp;
        logic [15:0] command;
        logic [15:0] offset;
        logic [15:0] upper;
        logic [15:0] lower;
        logic [15:0] rate;
        logic [15:0] misc;
        logic [7:0]  stat_vout;
        logic [7:0]  stat_cml;
        logic [15:0] target;
        logic [15:0] dac;
        logic [10:0] ramp_cnt;
        logic        alert_oe_n;
        logic [7:0]  backup;
    } vtl_core_s;

    vtl_lnk_s  l;
    vtl_lnk_s  next_l;
    vtl_core_s c;
    vtl_core_s next_c;

    // clamp command plus offset against limits and dac range
    function automatic vtl_tgt_s eval_target(input logic [15:0] cmd, input logic [15:0] off,
                                             input logic [15:0] up, input logic [15:0] lo,
                                             input logic [15:0] dmax);
        logic signed [17:0] sum;
        eval_target = '0;
        sum = $signed({2'b00, cmd}) + $signed({{2{off[15]}}, off});
        if (sum > $signed({2'b00, up})) begin
            eval_target.code = up;
            eval_target.warn = 1'b1;
        end else if (sum < $signed({2'b00, lo})) begin
            eval_target.code = lo;
            eval_target.warn = 1'b1;
        end else if (sum > $signed({2'b00, dmax})) begin
            eval_target.code = dmax;
        end else begin
            eval_target.code = sum[15:0];
        end
    endfunction

    // shift from the fixed -12 exponent to the active one
    function automatic logic [3:0] exp_shift(input logic [4:0] e);
        logic [4:0] s;
        s = e + EXP_BIAS;
        exp_shift = s[3:0];
    endfunction

    // valid range upper bound for the loop scale, in active lsb
    function automatic logic [15:0] range_limit(input logic [1:0] sc, input logic [4:0] e);
        logic [15:0] base;
        case (sc)
            2'h0: base = RANGE_S1000;
            2'h1: base = RANGE_S0500;
            2'h2: base = RANGE_S0250;
            default: base = RANGE_S0125;
        endcase
        range_limit = base >> exp_shift(e);
    endfunction

    // link side: take one request, wait for the core's answer
    always_comb begin
        next_l = l;
        next_l.rsp_valid = 1'b0;
        next_l.ack_s1 = c.ack_tgl;
        next_l.ack_s2 = l.ack_s1;
        case (l.st)
            LNK_IDLE: begin
                if (link_valid_i) begin
                    next_l.req = link_req_i;
                    next_l.req_tgl = ~l.req_tgl;
                    next_l.ready = 1'b0;
                    next_l.st = LNK_BUSY;
                end
            end
            LNK_BUSY: begin
                if (l.ack_s2 == l.req_tgl) begin
                    next_l.rsp = c.rsp;  // held stable by the core
                    next_l.rsp_valid = 1'b1;
                    next_l.ready = 1'b1;
                    next_l.st = LNK_IDLE;
                end
            end
            default: begin
                next_l.st = LNK_IDLE;
                next_l.ready = 1'b1;
            end
        endcase
    end

    // link-domain registers
    always_ff @(posedge link_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            l <= '0;
            l.st <= LNK_IDLE;
            l.ready <= 1'b1;
        end else begin
            l <= next_l;
        end
    end

    // core side: synchronisers, command execution, clamp and ramp
    always_comb begin
        logic        exec;
        logic        flt_edge;
        logic        wr_warn;
        logic        inv_cmd;
        logic        inv_data;
        logic [15:0] dmax;
        logic [15:0] d;
        logic [15:0] rd;
        logic signed [17:0] chk;
        logic signed [23:0] wide;
        vtl_tgt_s    t;
        exec = 1'b0;
        flt_edge = 1'b0;
        wr_warn = 1'b0;
        inv_cmd = 1'b0;
        inv_data = 1'b0;
        rd = '0;
        chk = '0;
        t = '0;
        wide = '0;
        dmax = range_limit(c.misc[MISC_SCALE +: 2], c.exp);
        d = l.req.data;
        next_c = c;
        next_c.req_s1 = l.req_tgl;
        next_c.req_s2 = c.req_s1;
        next_c.cen_s1 = conv_enable_i;
        next_c.cen_s2 = c.cen_s1;
        next_c.flt_s1 = fault_shutdown_i;
        next_c.flt_s2 = c.flt_s1;
        next_c.flt_d = c.flt_s2;
        next_c.pin_s1 = voltage_select_pin_i;
        next_c.pin_s2 = c.pin_s1;
        next_c.nvc_s1 = nvm_command_i;
        next_c.nvc_s2 = c.nvc_s1;
        next_c.nvo_s1 = nvm_offset_i;
        next_c.nvo_s2 = c.nvo_s1;
        next_c.al_s1 = alert_i;
        next_c.al_s2 = c.al_s1;
        // boot: load command and offset once the inputs have settled
        if (c.boot != BOOT_CYC) begin
            next_c.boot = c.boot + 4'h1;
            if (c.boot == BOOT_CYC - 4'h1) begin
                next_c.command = c.misc[MISC_SRC_PIN] ? c.pin_s2 : c.nvc_s2;
                wide = $signed({{16{c.nvo_s2[7]}}, c.nvo_s2}) >>> exp_shift(c.exp);
                next_c.offset = wide[15:0];
            end
        end else begin
            exec = (c.req_s2 != c.ack_tgl);
            flt_edge = c.flt_s2 & ~c.flt_d;
        end

        // fault restart: keep or reload the command
        if (flt_edge && c.misc[MISC_RESTORE]) begin
            next_c.command = c.misc[MISC_SRC_PIN] ? c.pin_s2 : c.nvc_s2;
        end

        // status clears come first so a new event wins
        if (exec && l.req.wr) begin
            case (l.req.code)
                CMD_CLEAR_FAULTS: begin
                    next_c.stat_vout = '0;
                    next_c.stat_cml = '0;
                end
                CMD_STAT_VOUT: next_c.stat_vout = c.stat_vout & ~d[7:0];
                CMD_STAT_CML: next_c.stat_cml = c.stat_cml & ~d[7:0];
                default: ;
            endcase
        end

        // execute the request
        if (exec) begin
            next_c.ack_tgl = c.req_s2;
            if (l.req.wr) begin
                case (l.req.code)
                    CMD_MODE: begin
                        if (c.cen_s2 || d[MODE_REL] || (d[6:5] != 2'b00) ||
                            ($signed(d[4:0]) > EXP_HI) || ($signed(d[4:0]) < EXP_LO)) begin
                            inv_data = 1'b1;
                        end else begin
                            next_c.exp = d[4:0];
                        end
                    end
                    CMD_COMMAND: begin
                        next_c.command = d;
                        t = eval_target(d, c.offset, c.upper, c.lower, dmax);
                        wr_warn = t.warn;
                    end
                    CMD_OFFSET: begin
                        chk = $signed({2'b00, next_c.command}) + $signed({{2{d[15]}}, d});
                        if ((chk < 18'sd0) || (chk > $signed({2'b00, dmax}))) begin
                            inv_data = 1'b1;
                        end else begin
                            next_c.offset = d;
                            t = eval_target(next_c.command, d, c.upper, c.lower, dmax);
                            wr_warn = t.warn;
                        end
                    end
                    CMD_UPPER: begin
                        next_c.upper = d;
                        t = eval_target(next_c.command, c.offset, d, c.lower, dmax);
                        wr_warn = t.warn;
                    end
                    CMD_LOWER: begin
                        next_c.lower = d;
                        t = eval_target(next_c.command, c.offset, c.upper, d, dmax);
                        wr_warn = t.warn;
                    end
                    CMD_RATE: next_c.rate = d;
                    CMD_MISC: next_c.misc = d & ~(16'h0001 << MISC_ALERT_RD);
                    CMD_CLEAR_FAULTS, CMD_STAT_VOUT, CMD_STAT_CML: ;
                    default: inv_cmd = 1'b1;
                endcase
            end else begin
                case (l.req.code)
                    CMD_MODE: rd = {11'h000, c.exp};
                    CMD_COMMAND: rd = c.command;
                    CMD_OFFSET: rd = c.offset;
                    CMD_UPPER: rd = c.upper;
                    CMD_LOWER: rd = c.lower;
                    CMD_RATE: rd = c.rate;
                    CMD_MISC: rd = c.misc | ({15'h0000, c.al_s2} << MISC_ALERT_RD);
                    CMD_STAT_BYTE: begin
                        rd[STB_NOTA] = |c.stat_vout;
                        rd[STB_CML] = |c.stat_cml;
                    end
                    CMD_STAT_WORD: begin
                        rd[STB_NOTA] = |c.stat_vout;
                        rd[STB_CML] = |c.stat_cml;
                        rd[SW_VOUT] = |c.stat_vout;
                    end
                    CMD_STAT_VOUT: rd = {8'h00, c.stat_vout};
                    CMD_STAT_CML: rd = {8'h00, c.stat_cml};
                    default: inv_cmd = 1'b1;
                endcase
            end
            next_c.rsp.data = rd;
            next_c.rsp.err = inv_cmd | inv_data;
        end

        // sticky status sets
        if (wr_warn) begin
            next_c.stat_vout[SV_MAXMIN] = 1'b1;
        end
        if (inv_cmd) begin
            next_c.stat_cml[CML_INV_CMD] = 1'b1;
        end
        if (inv_data) begin
            next_c.stat_cml[CML_INV_DATA] = 1'b1;
        end

        // clamped target follows every register change
        t = eval_target(c.command, c.offset, c.upper, c.lower, dmax);
        next_c.target = t.code;

        // ramp one lsb per rate period while converting
        if (!c.cen_s2) begin
            next_c.dac = c.target;
            next_c.ramp_cnt = '0;
        end else if (c.dac != c.target) begin
            if (c.ramp_cnt >= c.rate[10:0]) begin
                next_c.ramp_cnt = '0;
                next_c.dac = (c.dac < c.target) ? c.dac + 16'h0001 : c.dac - 16'h0001;
            end else begin
                next_c.ramp_cnt = c.ramp_cnt + 11'h001;
            end
        end else begin
            next_c.ramp_cnt = '0;
        end

        // alert line pulled low while an unmasked status is set
        next_c.alert_oe_n = ~(((|c.stat_vout) & ~c.misc[MISC_MASK_WARN]) |
                              ((|c.stat_cml) & ~c.misc[MISC_MASK_CML]));

        // saturated 8-bit backup of the offset at exponent -12
        wide = $signed({{8{c.offset[15]}}, c.offset}) <<< exp_shift(c.exp);
        if (wide > BACKUP_MAX) begin
            next_c.backup = BACKUP_MAX[7:0];
        end else if (wide < BACKUP_MIN) begin
            next_c.backup = BACKUP_MIN[7:0];
        end else begin
            next_c.backup = wide[7:0];
        end
    end

    // core-domain registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            c <= '0;
            c.exp <= RST_EXP;
            c.upper <= RST_UPPER;
            c.lower <= RST_LOWER;
            c.rate <= RST_RATE;
            c.misc <= RST_MISC;
            c.alert_oe_n <= 1'b1;
        end else begin
            c <= next_c;
        end
    end

    // outputs straight from flops, except alert_o which is tied low
    assign link_ready_o = l.ready;
    assign link_rsp_valid_o = l.rsp_valid;
    assign link_rsp_o = l.rsp;
    assign alert_o = 1'b0;
    assign alert_oe_n_o = c.alert_oe_n;
    assign dac_code_o = c.dac;
    assign offset_backup_o = c.backup;

endmodule

`default_nettype wire

// ### testbench/vtl_target_monitor.sv
// concurrent checks on the target block ports
`timescale 1ns/1ps
`default_nettype none
module vtl_monitor
    import vtl_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        link_clk_i,
    input  wire logic        link_valid_i,
    input  wire logic        link_ready_o,
    input  wire logic        link_rsp_valid_o,
    input  wire vtl_rsp_s    link_rsp_o,
    input  wire logic        conv_enable_i,
    input  wire logic        alert_o,
    input  wire logic        alert_oe_n_o,
    input  wire logic [15:0] dac_code_o
);
    logic [2:0] conv_cnt;
    // cycles with conversion requested, saturating so the synchroniser has settled
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            conv_cnt <= 3'h0;
        end else if (!conv_enable_i) begin
            conv_cnt <= 3'h0;
        end else if (conv_cnt != 3'h7) begin
            conv_cnt <= conv_cnt + 3'h1;
        end
    end
    // link handshake and answer timing
    a_take_busy: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
        link_valid_i && link_ready_o |=> !link_ready_o) else $error("ready stayed high after a take");
    a_answer_late: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
        $fell(link_ready_o) |-> ##[1:12] link_rsp_valid_o) else $error("no answer in time");
    a_rsp_pulse: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
        link_rsp_valid_o |=> !link_rsp_valid_o) else $error("answer valid too long");
    a_rsp_ready: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
        link_rsp_valid_o |-> link_ready_o) else $error("ready not back with answer");
    a_rsp_origin: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
        link_rsp_valid_o |-> !$past(link_ready_o)) else $error("answer without a request");
    a_rsp_hold: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
        !link_rsp_valid_o |-> $stable(link_rsp_o)) else $error("answer data moved");
    // open-drain data and slewed reference
    a_alert_data: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !alert_o) else $error("alert data driven high");
    a_ramp_step: assert property (@(posedge clk_i) disable iff (!resetn_i)
        conv_cnt == 3'h7 && $changed(dac_code_o) |-> dac_code_o == $past(dac_code_o) + 16'h1
        || dac_code_o == $past(dac_code_o) - 16'h1) else $error("reference jumped while converting");
    // main scenarios
    c_take: cover property (@(posedge link_clk_i) link_valid_i && link_ready_o);
    c_alert: cover property (@(posedge clk_i) $fell(alert_oe_n_o));
    c_ramp: cover property (@(posedge clk_i) conv_cnt == 3'h7 && $changed(dac_code_o));
endmodule
`default_nettype wire

// ### testbench/vtl_host_model.sv
// host model issuing word transfers on the link
`timescale 1ns/1ps
`default_nettype none
module vtl_host_model
    import vtl_pkg::*;
(
    output logic          link_clk_o,
    output logic          link_valid_o,
    output vtl_req_s      link_req_o,
    input  wire logic     link_ready_i,
    input  wire logic     link_rsp_valid_i,
    input  wire vtl_rsp_s link_rsp_i
);
    logic run = 1'b0;
    int   n;
    // link clock runs only while xfer or tick holds run high
    initial begin
        link_clk_o = 1'b0;
        forever #32 link_clk_o = run ? ~link_clk_o : 1'b0;
    end
    // idle request lines
    initial begin
        link_valid_o = 1'b0;
        link_req_o = '0;
    end
    // run the link clock for some cycles
    task automatic tick(input int c);
        run = 1'b1;
        repeat (c) @(posedge link_clk_o);
        run = 1'b0;
    endtask
    // one word held until taken, answer taken on its own edge
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data, output vtl_rsp_s rsp);
        run = 1'b1;
        @(posedge link_clk_o);
        #1;
        link_req_o = '{wr: wr, code: code, data: data};
        link_valid_o = 1'b1;
        n = 0;
        do begin
            @(posedge link_clk_o);
            n++;
        end while (link_ready_i !== 1'b1 && n < 20);
        #1;
        link_valid_o = 1'b0;
        link_req_o.data = ~data;
        n = 0;
        do begin
            @(posedge link_clk_o);
            n++;
        end while (link_rsp_valid_i !== 1'b1 && n < 20);
        rsp = link_rsp_i;
        if (n == 20) rsp = 'x;
        tick(2);
    endtask
endmodule
`default_nettype wire

// ### testbench/tb_vout_target_trim_limit_logic.sv
// self-checking bench for the output-voltage target logic
`timescale 1ns/1ps
`default_nettype none
module tb_vout_target_trim_limit_logic
    import vtl_pkg::*;
;
    typedef struct packed {
        logic        wr;
        logic [7:0]  code;
        logic [15:0] data;
        logic        err;
        logic [15:0] rd;
        logic [15:0] dac;
        logic        oe;
    } vtl_row_s;
    // access, error, read data, reference code, alert enable
    localparam vtl_row_s ROWS [25] = '{
        {1'h0, 8'h22, 16'h0000, 1'h0, 16'h0010, 16'h0410, 1'h1}, {1'h1, 8'h22, 16'h0020, 1'h0, 16'h0, 16'h0420, 1'h1},
        {1'h1, 8'h22, 16'hfff0, 1'h0, 16'h0, 16'h03f0, 1'h1}, {1'h1, 8'h21, 16'h0c00, 1'h0, 16'h0, 16'h0b33, 1'h1},
        {1'h0, 8'h7a, 16'h0000, 1'h0, 16'h0000, 16'h0b33, 1'h1}, {1'h1, 8'h22, 16'h0200, 1'h1, 16'h0, 16'h0b33, 1'h0},
        {1'h0, 8'h7e, 16'h0000, 1'h0, 16'h0040, 16'h0b33, 1'h0}, {1'h1, 8'h7e, 16'h0040, 1'h0, 16'h0, 16'h0b33, 1'h1},
        {1'h1, 8'h21, 16'h0800, 1'h0, 16'h0, 16'h07f0, 1'h1}, {1'h1, 8'h24, 16'h0700, 1'h0, 16'h0, 16'h0700, 1'h0},
        {1'h0, 8'h78, 16'h0000, 1'h0, 16'h0001, 16'h0700, 1'h0}, {1'h0, 8'h79, 16'h0000, 1'h0, 16'h8001, 16'h0700, 1'h0},
        {1'h1, 8'h03, 16'h0000, 1'h0, 16'h0, 16'h0700, 1'h1}, {1'h1, 8'h24, 16'h6000, 1'h0, 16'h0, 16'h07f0, 1'h1},
        {1'h1, 8'h2b, 16'h0700, 1'h0, 16'h0, 16'h07f0, 1'h1}, {1'h1, 8'h21, 16'h0600, 1'h0, 16'h0, 16'h0700, 1'h0},
        {1'h0, 8'h7a, 16'h0000, 1'h0, 16'h0008, 16'h0700, 1'h0}, {1'h1, 8'h03, 16'h0000, 1'h0, 16'h0, 16'h0700, 1'h1},
        {1'h1, 8'he0, 16'h0004, 1'h0, 16'h0, 16'h0700, 1'h1}, {1'h0, 8'he0, 16'h0000, 1'h0, 16'h8004, 16'h0700, 1'h1},
        {1'h1, 8'h21, 16'h0500, 1'h0, 16'h0, 16'h0700, 1'h1}, {1'h1, 8'h55, 16'h0000, 1'h1, 16'h0, 16'h0700, 1'h0},
        {1'h1, 8'h20, 16'h0008, 1'h1, 16'h0, 16'h0700, 1'h0}, {1'h1, 8'h20, 16'h0080, 1'h1, 16'h0, 16'h0700, 1'h0},
        {1'h1, 8'h03, 16'h0000, 1'h0, 16'h0, 16'h0700, 1'h1}};
    logic        clk, resetn, conv, fault, lclk, lvalid, lready, rvalid, oe_n, alert_d, alert_line;
    logic [15:0] pin, nvm_cmd, dac;
    logic [7:0]  nvm_off, backup;
    vtl_req_s    req;
    vtl_rsp_s    rsp_w, rsp;
    int          fails = 0, checked = 0, cyc = 0;
    logic [15:0] offs [3] = '{16'h0300, 16'hff00, 16'hffa0};
    logic [7:0]  bkp [3] = '{8'h7f, 8'h80, 8'ha0};
    logic [15:0] modes [3] = '{16'h0000, 16'h0001, 16'h0003};
    logic [15:0] rest [3] = '{16'h0300, 16'h0400, 16'h0600};
    // open-drain alert wire with pull-up
    assign alert_line = oe_n ? 1'b1 : alert_d;
    vtl_target uut (.clk_i(clk), .resetn_i(resetn), .link_clk_i(lclk), .link_valid_i(lvalid), .link_req_i(req),
        .link_ready_o(lready), .link_rsp_valid_o(rvalid), .link_rsp_o(rsp_w), .conv_enable_i(conv),
        .fault_shutdown_i(fault), .voltage_select_pin_i(pin), .nvm_command_i(nvm_cmd), .nvm_offset_i(nvm_off),
        .alert_i(alert_line), .alert_o(alert_d), .alert_oe_n_o(oe_n), .dac_code_o(dac), .offset_backup_o(backup));
    vtl_host_model host (.link_clk_o(lclk), .link_valid_o(lvalid), .link_req_o(req), .link_ready_i(lready),
        .link_rsp_valid_i(rvalid), .link_rsp_i(rsp_w));
    // core clock and hang guard
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [7:0] c, input logic [15:0] d);
        host.xfer(wr, c, d, rsp);
        repeat (4) @(negedge clk);
    endtask
    task automatic do_reset();
        @(negedge clk);
        resetn = 1'b0;
        host.tick(3);
        check("ready", {15'h0, lready}, 16'h0001);
        check("alert_oe_n", {15'h0, oe_n}, 16'h0001);
        check("dac", dac, 16'h0000);
        @(negedge clk);
        resetn = 1'b1;
        repeat (8) @(negedge clk);
    endtask
    // table, then backup, fault restore, ramp and a second reset
    initial begin
        resetn = 1'b0;
        conv = 1'b0;
        fault = 1'b0;
        pin = 16'h0600;
        nvm_cmd = 16'h0400;
        nvm_off = 8'h10;
        do_reset();
        foreach (ROWS[i]) begin
            bus(ROWS[i].wr, ROWS[i].code, ROWS[i].data);
            check("err", {15'h0, rsp.err}, {15'h0, ROWS[i].err});
            if (!ROWS[i].wr) check("read", rsp.data, ROWS[i].rd);
            check("dac", dac, ROWS[i].dac);
            check("alert_oe_n", {15'h0, oe_n}, {15'h0, ROWS[i].oe});
        end
        bus(1'b1, CMD_MISC, 16'h0000);
        bus(1'b1, CMD_LOWER, 16'h0000);
        bus(1'b1, CMD_COMMAND, 16'h0200);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, CMD_OFFSET, offs[i]);
            check("backup", {8'h0, backup}, {8'h0, bkp[i]});
            check("dac", dac, 16'h0200 + offs[i]);
        end
        bus(1'b1, CMD_OFFSET, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, CMD_MISC, modes[i]);
            bus(1'b1, CMD_COMMAND, 16'h0300);
            fault = 1'b1;
            repeat (4) @(negedge clk);
            fault = 1'b0;
            repeat (6) @(negedge clk);
            bus(1'b0, CMD_COMMAND, 16'h0000);
            check("restored", rsp.data, rest[i]);
            check("dac", dac, rest[i]);
        end
        bus(1'b1, CMD_RATE, 16'h0003);
        conv = 1'b1;
        bus(1'b1, CMD_COMMAND, 16'h0610);
        check("ramping", {15'h0, dac !== 16'h0610}, 16'h0001);
        repeat (80) @(negedge clk);
        check("dac", dac, 16'h0610);
        bus(1'b1, CMD_UPPER, 16'h0608);
        repeat (50) @(negedge clk);
        check("dac", dac, 16'h0608);
        check("alert_oe_n", {15'h0, oe_n}, 16'h0000);
        bus(1'b1, CMD_MODE, 16'h0014);
        check("err", {15'h0, rsp.err}, 16'h0001);
        conv = 1'b0;
        do_reset();
        bus(1'b0, CMD_UPPER, 16'h0000);
        check("upper", rsp.data, 16'h6000);
        bus(1'b0, CMD_OFFSET, 16'h0000);
        check("offset", rsp.data, 16'h0010);
        check("dac", dac, 16'h0410);
        bus(1'b1, CMD_MISC, 16'h0010);
        bus(1'b1, CMD_COMMAND, 16'h1000);
        check("dac", dac, 16'h1010);
        bus(1'b1, CMD_MODE, 16'h001c);
        check("err", {15'h0, rsp.err}, 16'h0000);
        bus(1'b0, CMD_MODE, 16'h0000);
        check("mode", rsp.data, 16'h001c);
        check("dac", dac, 16'h0016);
        check("backup", {8'h0, backup}, 16'h007f);
        finish_test();
    end
endmodule
bind vtl_target vtl_monitor u_mon (.clk_i(clk_i), .resetn_i(resetn_i), .link_clk_i(link_clk_i),
    .link_valid_i(link_valid_i), .link_ready_o(link_ready_o), .link_rsp_valid_o(link_rsp_valid_o),
    .link_rsp_o(link_rsp_o), .conv_enable_i(conv_enable_i), .alert_o(alert_o), .alert_oe_n_o(alert_oe_n_o),
    .dac_code_o(dac_code_o));
`default_nettype wire
